/* File: hdl/solcr_top.sv */
// Output path, bleed and lock detect configuration register bank
`timescale 1ns/1ns
module solcr_top (
   input  wire logic                         i_sys_clk,           // System clock, 20 MHz
   input  wire logic                         i_reset_n,           // Async reset, active low
   input  wire logic                         i_clk_en,            // Freezes all state when low
   input  wire logic                         i_wr_en,             // Register write strobe
   input  wire logic [solcr_pkg::ADDR_W-1:0] i_wr_addr,           // Write address
   input  wire logic [solcr_pkg::DATA_W-1:0] i_wr_data,           // Write data
   input  wire logic                         i_rd_en,             // Register read strobe
   input  wire logic [solcr_pkg::ADDR_W-1:0] i_rd_addr,           // Read address
   input  wire logic                         i_div_load,          // Buffered divider load pulse
   input  wire logic                         i_lock_detect,       // Digital lock detect, async
   output logic [solcr_pkg::DATA_W-1:0]      o_rd_data,           // Read data
   output logic                              o_rd_valid,          // Read data valid pulse
   output logic                              o_rd_hit,            // Read address was mapped
   output logic                              o_feedback_source_select, // 1: raw oscillator
   output logic [2:0]                        o_div_code,          // Applied divider code
   output logic [6:0]                        o_div_ratio,         // Applied division ratio
   output logic                              o_divider_double_buffer, // Divider buffered
   output logic                              o_mute_on_lock_reserved, // Reserved bit
   output logic                              o_quadrupler_path_enable, // x4 path on
   output logic                              o_doubler_path_enable, // x2 path on
   output logic                              o_rf_output_enable,  // RF output on
   output logic [1:0]                        o_output_power_code, // Output power level
   output logic [7:0]                        o_bleed_current_code, // Bleed magnitude
   output logic [1:0]                        o_lock_window_bias,  // Lock delay code
   output logic                              o_lock_precision_select, // 1: integer window
   output logic                              o_bleed_gate_on_lock, // Gated bleed selected
   output logic                              o_bleed_enable,      // Negative bleed enable
   output logic                              o_bleed_current_on,  // Bleed actually applied
   output logic                              o_osc_regulator_disable, // Regulator off bit
   output logic                              o_osc_regulator_on,  // Regulator running
   output logic [1:0]                        o_output_bias_reserved, // Reserved field
   output logic [7:0]                        o_lock_delay_dns,    // Lock delay, 0.1 ns
   output logic [7:0]                        o_lock_window_dns,   // Lock window, 0.1 ns
   output logic [1:0]                        o_lock_count_code,   // Lock count code
   output logic                              o_loss_of_lock_enable // Loss of lock enable
);
   import solcr_pkg::*;

   typedef struct packed {
      logic [7:0] fbdiv;
      logic [7:0] outp;
      logic [7:0] bleed;
      logic [7:0] ldb;
      logic [7:0] lcnt;
      logic       lock_s1;
      logic       lock_s2;
      logic       bleed_on;
      logic [7:0] dly_dns;
      logic [7:0] win_dns;
      logic [7:0] rd_data;
      logic       rd_valid;
      logic       rd_hit;
      logic       reg_on;
   } solcr_st_t;

   localparam solcr_st_t ST_RESET = '{
      fbdiv:    RST_FBDIV,
      outp:     RST_OUTP,
      bleed:    RST_BLEED,
      ldb:      RST_LDB,
      lcnt:     RST_LCNT,
      lock_s1:  1'b0,
      lock_s2:  1'b0,
      bleed_on: 1'b0,
      dly_dns:  LD_DLY3_DNS,
      win_dns:  LD_WIN_FRAC,
      rd_data:  8'h00,
      rd_valid: 1'b0,
      rd_hit:   1'b0,
      reg_on:   1'b0
   };

   solcr_st_t st_r;
   solcr_st_t st_nxt;

   solcr_div_if div_link ();

   solcr_divbuf u_divbuf (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_clk_en  (i_clk_en),
      .div       (div_link.divider)
   );

   assign div_link.stored_code = st_r.fbdiv[DIV_LSB +: 3];
   assign div_link.dbuf_en     = st_r.outp[DBUF_BIT];
   assign div_link.load        = i_div_load;

   always_comb begin
      st_nxt = st_r;

      // Lock detect comes from the analog side, two stages before use
      st_nxt.lock_s1 = i_lock_detect;
      st_nxt.lock_s2 = st_r.lock_s1;

      // Reserved bits are masked off, so they read zero and ignore writes
      if (i_wr_en) begin
         if (i_wr_addr == OFS_FBDIV) begin
            st_nxt.fbdiv = i_wr_data & WMASK_FBDIV;
         end else if (i_wr_addr == OFS_OUTP) begin
            st_nxt.outp = i_wr_data & WMASK_OUTP;
         end else if (i_wr_addr == OFS_BLEED) begin
            st_nxt.bleed = i_wr_data & WMASK_BLEED;
         end else if (i_wr_addr == OFS_LDB) begin
            st_nxt.ldb = i_wr_data & WMASK_LDB;
         end else if (i_wr_addr == OFS_LCNT) begin
            st_nxt.lcnt = i_wr_data & WMASK_LCNT;
         end
      end

      // Decoded values track the new register contents in the same edge
      case (st_nxt.ldb[BIAS_LSB +: 2])
         2'h0:    st_nxt.dly_dns = LD_DLY0_DNS;
         2'h1:    st_nxt.dly_dns = LD_DLY1_DNS;
         2'h2:    st_nxt.dly_dns = LD_DLY2_DNS;
         default: st_nxt.dly_dns = LD_DLY3_DNS;
      endcase
      st_nxt.win_dns = st_nxt.ldb[PREC_BIT] ? LD_WIN_INT : LD_WIN_FRAC;

      // Gating relies on software having lock detect running
      st_nxt.bleed_on = st_nxt.ldb[BLEED_EN_BIT]
                        & (~st_nxt.ldb[GATE_BIT] | st_r.lock_s2);

      // Inverted copy held in a flop so the output has no gate after it
      st_nxt.reg_on = ~st_nxt.ldb[LDO_PD_BIT];

      // Read returns the contents before any write in the same cycle
      st_nxt.rd_valid = i_rd_en;
      st_nxt.rd_hit   = 1'b0;
      st_nxt.rd_data  = 8'h00;
      if (i_rd_en) begin
         st_nxt.rd_hit = 1'b1;
         if (i_rd_addr == OFS_FBDIV) begin
            st_nxt.rd_data = st_r.fbdiv;
         end else if (i_rd_addr == OFS_OUTP) begin
            st_nxt.rd_data = st_r.outp;
         end else if (i_rd_addr == OFS_BLEED) begin
            st_nxt.rd_data = st_r.bleed;
         end else if (i_rd_addr == OFS_LDB) begin
            st_nxt.rd_data = st_r.ldb;
         end else if (i_rd_addr == OFS_LCNT) begin
            st_nxt.rd_data = st_r.lcnt;
         end else begin
            st_nxt.rd_hit = 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= ST_RESET;
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign o_rd_data                = st_r.rd_data;
   assign o_rd_valid               = st_r.rd_valid;
   assign o_rd_hit                 = st_r.rd_hit;
   assign o_feedback_source_select = st_r.fbdiv[FBSRC_BIT];
   assign o_div_code               = div_link.applied_code;
   assign o_div_ratio              = div_link.ratio;
   assign o_divider_double_buffer  = st_r.outp[DBUF_BIT];
   assign o_mute_on_lock_reserved  = st_r.outp[MUTE_BIT];
   assign o_quadrupler_path_enable = st_r.outp[X4_BIT];
   assign o_doubler_path_enable    = st_r.outp[X2_BIT];
   assign o_rf_output_enable       = st_r.outp[RFOUT_ON_BIT];
   assign o_output_power_code      = st_r.outp[PWR_LSB +: 2];
   assign o_bleed_current_code     = st_r.bleed;
   assign o_lock_window_bias       = st_r.ldb[BIAS_LSB +: 2];
   assign o_lock_precision_select  = st_r.ldb[PREC_BIT];
   assign o_bleed_gate_on_lock     = st_r.ldb[GATE_BIT];
   assign o_bleed_enable           = st_r.ldb[BLEED_EN_BIT];
   assign o_bleed_current_on       = st_r.bleed_on;
   assign o_osc_regulator_disable  = st_r.ldb[LDO_PD_BIT];
   assign o_osc_regulator_on       = st_r.reg_on;
   assign o_output_bias_reserved   = st_r.ldb[PBS_LSB +: 2];
   assign o_lock_delay_dns         = st_r.dly_dns;
   assign o_lock_window_dns        = st_r.win_dns;
   assign o_lock_count_code        = st_r.lcnt[LCNT_LSB +: 2];
   assign o_loss_of_lock_enable    = st_r.lcnt[LOL_BIT];
endmodule // solcr_top

/* File: include/solcr_pkg.sv */
// Constants and field layout of the output and lock configuration register slice
// Operation
// - Bit 7 of the divider register picks the divided output (0) or the raw oscillator (1) as feedback, reset 1.
// - A control bit makes the divider code double buffered so a written code waits for a later load event, reset 0.
// - Bits 1 to 0 of the output register pick one of four power levels, code 3 being the highest at 5 dBm, reset 3.
// - The output path register at 0x25 resets to 0x07.
// - The bleed current register is a full eight-bit read-write code that resets to 0x32.
// - Bits 7 to 6 of the lock register set the lock window delay to 5, 6, 8 or 12 ns, reset 3.
// - The lock precision bit picks a 5 ns fractional window at 0 or a 2.4 ns integer window at 1, reset 0.
// - With the gated-bleed bit set the bleed current follows digital lock detect, which software must have enabled first, reset 0.
// - Bit 3 of the lock register switches the negative bleed current on at 1, reset 0.
// - The oscillator regulator runs when its control bit is 0 and is off at 1, reset 1, and software should keep it off.
// - The lock and bleed register at 0x27 resets to 0xc5 and every field is read-write.
// - The register at 0x28 resets to 0x03 and its bits 7 to 3 read as zero and ignore writes.
package solcr_pkg;
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 8;
   localparam int          DIV_CODE_W    = 3;
   localparam int          DIV_RATIO_W   = 7;

   // Byte offsets
   localparam logic [7:0]  OFS_FBDIV     = 8'h24;
   localparam logic [7:0]  OFS_OUTP      = 8'h25;
   localparam logic [7:0]  OFS_BLEED     = 8'h26;
   localparam logic [7:0]  OFS_LDB       = 8'h27;
   localparam logic [7:0]  OFS_LCNT      = 8'h28;

   // Reset values
   localparam logic [7:0]  RST_FBDIV     = 8'h80;
   localparam logic [7:0]  RST_OUTP      = 8'h07;
   localparam logic [7:0]  RST_BLEED     = 8'h32;
   localparam logic [7:0]  RST_LDB       = 8'hc5;
   localparam logic [7:0]  RST_LCNT      = 8'h03;

   // Writable bits; the rest are reserved and read as zero
   localparam logic [7:0]  WMASK_FBDIV   = 8'hf0;
   localparam logic [7:0]  WMASK_OUTP    = 8'hbf;
   localparam logic [7:0]  WMASK_BLEED   = 8'hff;
   localparam logic [7:0]  WMASK_LDB     = 8'hff;
   localparam logic [7:0]  WMASK_LCNT    = 8'h07;

   // Field positions
   localparam int          FBSRC_BIT     = 7;
   localparam int          DIV_LSB       = 4;
   localparam int          MUTE_BIT      = 7;
   localparam int          DBUF_BIT      = 5;
   localparam int          X4_BIT        = 4;
   localparam int          X2_BIT        = 3;
   localparam int          RFOUT_ON_BIT  = 2;
   localparam int          PWR_LSB       = 0;
   localparam int          BIAS_LSB      = 6;
   localparam int          PREC_BIT      = 5;
   localparam int          GATE_BIT      = 4;
   localparam int          BLEED_EN_BIT  = 3;
   localparam int          LDO_PD_BIT    = 2;
   localparam int          PBS_LSB       = 0;
   localparam int          LCNT_LSB      = 1;
   localparam int          LOL_BIT       = 0;

   localparam logic [2:0]  DIV_CODE_RSVD = 3'h7;

   // Lock timing in tenths of a nanosecond
   localparam logic [7:0]  LD_DLY0_DNS   = 8'h32;
   localparam logic [7:0]  LD_DLY1_DNS   = 8'h3c;
   localparam logic [7:0]  LD_DLY2_DNS   = 8'h50;
   localparam logic [7:0]  LD_DLY3_DNS   = 8'h78;
   localparam logic [7:0]  LD_WIN_FRAC   = 8'h32;
   localparam logic [7:0]  LD_WIN_INT    = 8'h18;
endpackage

/* File: include/solcr_div_if.sv */
// Carrier between the register bank and the output divider buffer
`timescale 1ns/1ns
interface solcr_div_if;
   logic [2:0] stored_code;
   logic       dbuf_en;
   logic       load;
   logic [2:0] applied_code;
   logic [6:0] ratio;

   modport cfg (output stored_code, output dbuf_en, output load,
                input applied_code, input ratio);
   modport divider (input stored_code, input dbuf_en, input load,
                    output applied_code, output ratio);
endinterface

/* File: hdl/solcr_divbuf.sv */
// Output divider code holding stage with optional double buffering
`timescale 1ns/1ns
module solcr_divbuf (
   input  wire logic   i_sys_clk,   // System clock
   input  wire logic   i_reset_n,   // Async reset, active low
   input  wire logic   i_clk_en,    // Freezes state when low
   solcr_div_if.divider div         // Divider code link
);
   import solcr_pkg::*;

   typedef struct packed {
      logic [2:0] code;
      logic [6:0] ratio;
   } solcr_dbst_t;

   localparam solcr_dbst_t DB_RESET = '{code: 3'h0, ratio: 7'h01};

   solcr_dbst_t st_r;
   solcr_dbst_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      // Direct mode follows the register; buffered mode waits for load
      if (!div.dbuf_en || div.load) begin
         // Reserved code keeps the last valid ratio
         if (div.stored_code != DIV_CODE_RSVD) begin
            st_nxt.code  = div.stored_code;
            st_nxt.ratio = 7'h01 << div.stored_code;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= DB_RESET;
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign div.applied_code = st_r.code;
   assign div.ratio        = st_r.ratio;
endmodule // solcr_divbuf

/* File: verif/solcr_props.sv */
// Port-level assertions for the output and lock configuration register bank
`timescale 1ns/1ns
module solcr_props (
   input wire logic       i_sys_clk,               // Clock
   input wire logic       i_reset_n,               // Reset, low
   input wire logic       i_clk_en,                // Enable
   input wire logic       i_wr_en,                 // Write strobe
   input wire logic [7:0] i_wr_addr,               // Write address
   input wire logic [7:0] i_wr_data,               // Write data
   input wire logic       i_rd_en,                 // Read strobe
   input wire logic       i_div_load,              // Divider load
   input wire logic       o_rd_valid,              // Read valid
   input wire logic [2:0] o_div_code,              // Applied code
   input wire logic [6:0] o_div_ratio,             // Ratio
   input wire logic       o_divider_double_buffer, // Buffered mode
   input wire logic [1:0] o_output_power_code,     // Power
   input wire logic [7:0] o_bleed_current_code,    // Bleed code
   input wire logic       o_bleed_enable,          // Bleed enable
   input wire logic       o_bleed_gate_on_lock,    // Gate bit
   input wire logic       o_bleed_current_on,      // Bleed applied
   input wire logic       o_osc_regulator_disable, // Regulator bit
   input wire logic       o_osc_regulator_on,      // Regulator state
   input wire logic [1:0] o_lock_window_bias,      // Delay code
   input wire logic [7:0] o_lock_delay_dns         // Delay
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   logic wr_ok;
   assign wr_ok = i_clk_en && i_wr_en;
   a_rd_answer: assert property (i_clk_en && i_rd_en |=> o_rd_valid)
      else $error("read valid missing");
   a_ratio_decode: assert property (o_div_code != 3'h7 && o_div_ratio == 7'h01 << o_div_code)
      else $error("divider ratio wrong");
   a_pwr_write: assert property (wr_ok && i_wr_addr == 8'h25
      |=> o_output_power_code == $past(i_wr_data[1:0])) else $error("power not stored");
   a_bleed_write: assert property (wr_ok && i_wr_addr == 8'h26
      |=> o_bleed_current_code == $past(i_wr_data)) else $error("bleed code not stored");
   a_reg_polarity: assert property (o_osc_regulator_on == !o_osc_regulator_disable)
      else $error("regulator polarity wrong");
   a_delay_decode: assert property (o_lock_delay_dns == (o_lock_window_bias == 2'h0 ? 8'h32 :
      o_lock_window_bias == 2'h1 ? 8'h3c : o_lock_window_bias == 2'h2 ? 8'h50 : 8'h78))
      else $error("lock delay wrong");
   a_bleed_off: assert property (!o_bleed_enable && !$past(o_bleed_enable)
      && $past(i_clk_en) |-> !o_bleed_current_on) else $error("bleed on while disabled");
   a_bleed_steady: assert property (o_bleed_enable && !o_bleed_gate_on_lock && $past(i_clk_en)
      && $past(o_bleed_enable && !o_bleed_gate_on_lock) |-> o_bleed_current_on)
      else $error("ungated bleed off");
   a_dbuf_hold: assert property ($past(o_divider_double_buffer) && !$past(i_div_load)
      |-> $stable(o_div_code)) else $error("buffered code moved without load");
endmodule // solcr_props

bind solcr_top solcr_props u_props (.i_sys_clk, .i_reset_n, .i_clk_en, .i_wr_en, .i_wr_addr,
   .i_wr_data, .i_rd_en, .i_div_load, .o_rd_valid, .o_div_code, .o_div_ratio,
   .o_divider_double_buffer, .o_output_power_code, .o_bleed_current_code, .o_bleed_enable,
   .o_bleed_gate_on_lock, .o_bleed_current_on, .o_osc_regulator_disable, .o_osc_regulator_on,
   .o_lock_window_bias, .o_lock_delay_dns);

/* File: verif/solcr_top_test.sv */
// Self-checking bench for the output and lock configuration register bank
`timescale 1ns/1ns
module solcr_top_test;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
   logic       i_sys_clk = 1'b0, i_reset_n = 1'b0, i_clk_en = 1'b1, i_wr_en = 1'b0;
   logic       i_rd_en = 1'b0, i_div_load = 1'b0, i_lock_detect = 1'b0;
   logic [7:0] i_wr_addr = 8'h00, i_wr_data = 8'h00, i_rd_addr = 8'h00;
   logic [7:0] o_rd_data, o_bleed_current_code, o_lock_delay_dns, o_lock_window_dns;
   logic [6:0] o_div_ratio;
   logic [2:0] o_div_code;
   logic [1:0] o_output_power_code;
   logic       o_rd_valid, o_rd_hit, o_feedback_source_select, o_quadrupler_path_enable;
   logic       o_doubler_path_enable, o_rf_output_enable, o_bleed_current_on, o_osc_regulator_on;
   logic [1:0] o_lock_window_bias, o_output_bias_reserved, o_lock_count_code;
   logic       o_divider_double_buffer, o_mute_on_lock_reserved, o_bleed_enable;
   logic       o_lock_precision_select, o_bleed_gate_on_lock;
   logic       o_osc_regulator_disable, o_loss_of_lock_enable;
   logic [7:0] mdl [5];
   logic [7:0] msk [5] = '{8'hf0, 8'hbf, 8'hff, 8'hff, 8'h07};
   logic [7:0] dly [4] = '{8'h32, 8'h3c, 8'h50, 8'h78};
   int         failures = 0, checked = 0, cycles = 0, app = 0;
   integer     seed = 32'ha12c4a53;

   solcr_top u_solcr_top (.i_sys_clk, .i_reset_n, .i_clk_en, .i_wr_en, .i_wr_addr, .i_wr_data,
      .i_rd_en, .i_rd_addr, .i_div_load, .i_lock_detect, .o_rd_data, .o_rd_valid, .o_rd_hit,
      .o_feedback_source_select, .o_div_code, .o_div_ratio, .o_divider_double_buffer,
      .o_mute_on_lock_reserved, .o_quadrupler_path_enable, .o_doubler_path_enable,
      .o_rf_output_enable, .o_output_power_code, .o_bleed_current_code, .o_lock_window_bias,
      .o_lock_precision_select, .o_bleed_gate_on_lock, .o_bleed_enable,
      .o_bleed_current_on, .o_osc_regulator_disable, .o_osc_regulator_on,
      .o_output_bias_reserved, .o_lock_delay_dns, .o_lock_window_dns, .o_lock_count_code,
      .o_loss_of_lock_enable);

   always #25 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         results();
      end
   end

   task automatic results();
      $display("counts: checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Model applies the stored code only when unbuffered; code 7 never reaches the divider
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk) #1;
      i_wr_en = 1'b1;
      i_wr_addr = a;
      i_wr_data = d;
      @(posedge i_sys_clk) #1;
      i_wr_en = 1'b0;
      if (i_clk_en && a >= 8'h24 && a <= 8'h28) mdl[a - 8'h24] = d & msk[a - 8'h24];
      if (!mdl[1][5] && mdl[0][6:4] != 3'h7) app = mdl[0][6:4];
   endtask

   task automatic rd(input logic [7:0] a);
      logic hit;
      hit = a >= 8'h24 && a <= 8'h28;
      @(posedge i_sys_clk) #1;
      i_rd_en = 1'b1;
      i_rd_addr = a;
      @(posedge i_sys_clk) #1;
      i_rd_en = 1'b0;
      `CHK(o_rd_valid, 1'b1)
      `CHK(o_rd_hit, hit)
      `CHK(o_rd_data, hit ? mdl[a - 8'h24] : 8'h00)
   endtask

   task automatic ld();
      @(posedge i_sys_clk) #1;
      i_div_load = 1'b1;
      @(posedge i_sys_clk) #1;
      i_div_load = 1'b0;
      if (mdl[0][6:4] != 3'h7) app = mdl[0][6:4];
   endtask

   task automatic chk_div();
      `CHK(o_div_code, 3'(app))
      `CHK(o_div_ratio, 7'(1 << app))
   endtask

   initial begin
      mdl = '{8'h80, 8'h07, 8'h32, 8'hc5, 8'h03};
      repeat (3) @(posedge i_sys_clk);
      #1 i_reset_n = 1'b1;
      for (int a = 8'h23; a <= 8'h29; a++) rd(8'(a));
      chk_div();
      `CHK({o_feedback_source_select, o_rf_output_enable, o_output_power_code}, 4'hf)
      `CHK(o_lock_delay_dns, 8'h78)
      `CHK(o_lock_window_dns, 8'h32)
      `CHK(o_osc_regulator_on, 1'b0)
      $display("test reset values done");
      repeat (60) begin
         wr(8'h23 + 8'($unsigned($random(seed)) % 7), 8'($random(seed)));
         i_lock_detect = 1'($random(seed));
         rd(8'h23 + 8'($unsigned($random(seed)) % 7));
         chk_div();
         `CHK(o_feedback_source_select, mdl[0][7])
         `CHK({o_quadrupler_path_enable, o_doubler_path_enable, o_rf_output_enable}, mdl[1][4:2])
         `CHK(o_output_power_code, mdl[1][1:0])
         `CHK(o_bleed_current_code, mdl[2])
         `CHK(o_osc_regulator_on, !mdl[3][2])
         `CHK({o_mute_on_lock_reserved, o_divider_double_buffer}, {mdl[1][7], mdl[1][5]})
         `CHK({o_lock_window_bias, o_lock_precision_select}, mdl[3][7:5])
         `CHK({o_bleed_gate_on_lock, o_bleed_enable, o_osc_regulator_disable}, mdl[3][4:2])
         `CHK(o_output_bias_reserved, mdl[3][1:0])
         `CHK({o_lock_count_code, o_loss_of_lock_enable}, mdl[4][2:0])
      end
      $display("test random access done");
      for (int b = 0; b < 8; b++) begin
         wr(8'h27, {b[2:1], b[0], 5'h04});
         `CHK(o_lock_delay_dns, dly[b[2:1]])
         `CHK(o_lock_window_dns, b[0] ? 8'h18 : 8'h32)
      end
      $display("test lock decode done");
      i_lock_detect = 1'b0;
      wr(8'h27, 8'h08);
      @(posedge i_sys_clk) #1;
      `CHK(o_bleed_current_on, 1'b1)
      `CHK(o_osc_regulator_on, 1'b1)
      wr(8'h27, 8'h18);
      repeat (3) @(posedge i_sys_clk);
      #1;
      `CHK(o_bleed_current_on, 1'b0)
      i_lock_detect = 1'b1;
      repeat (3) @(posedge i_sys_clk);
      #1;
      `CHK(o_bleed_current_on, 1'b1)
      wr(8'h27, 8'h10);
      @(posedge i_sys_clk) #1;
      `CHK(o_bleed_current_on, 1'b0)
      $display("test bleed gating done");
      wr(8'h25, 8'h20);
      wr(8'h24, 8'h50);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk_div();
      ld();
      chk_div();
      wr(8'h24, 8'h70);
      ld();
      chk_div();
      wr(8'h25, 8'h07);
      @(posedge i_sys_clk) #1;
      chk_div();
      // Bleed code for an 8x feedback ratio and a 900 uA pump current
      wr(8'h26, 8'(400 * 900 / (8 * 375)));
      `CHK(o_bleed_current_code, 8'h78)
      // Frozen enable must swallow the write entirely
      i_clk_en = 1'b0;
      wr(8'h26, 8'ha5);
      i_clk_en = 1'b1;
      rd(8'h26);
      $display("test divider buffer done");
      results();
   end
endmodule // solcr_top_test
